// [shared/srr_regs.svh]
// constants of the sample rate reducer: rates, buffer sizes, widths, mode codes
`ifndef SRR_REGS_SVH
`define SRR_REGS_SVH
`define SRR_CONV_RATE_MSPS 100
`define SRR_SAMP_W         14
`define SRR_WORD_W         28
`define SRR_ADDR_W         14
`define SRR_CNT_W          15
`define SRR_N_W            16
`define SRR_MEM_DEPTH      16384
`define SRR_ACQ_DEPTH_DEF  15'h2000
`define SRR_ACQ_DEPTH_ALT  15'h4000
`define SRR_AWG_DEPTH_DEF  15'h1000
`define SRR_AWG_DEPTH_ALT  15'h4000
`define SRR_MODE_AVG       2'h0
`define SRR_MODE_DEC       2'h1
`define SRR_MODE_MM        2'h2
`endif

// [shared/srr_pkg.sv]
// types of the sample rate reducer
`include "srr_regs.svh"
package srr_pkg;
  typedef enum logic [1:0] {
    SRR_AVG = `SRR_MODE_AVG,
    SRR_DEC = `SRR_MODE_DEC,
    SRR_MM  = `SRR_MODE_MM
  } srr_mode_t;

  typedef enum logic [3:0] {
    A_IDLE = 4'h1,
    A_RUN  = 4'h2,
    A_MAX  = 4'h4,
    A_FULL = 4'h8
  } srr_acq_st_t;

  typedef enum logic [2:0] {
    W_IDLE  = 3'h1,
    W_PRIME = 3'h2,
    W_PLAY  = 3'h4
  } srr_awg_st_t;

  typedef struct packed {
    srr_acq_st_t                     ast;
    srr_awg_st_t                     wst;
    logic [`SRR_N_W:0]               grp;
    logic signed [29:0]              acc0;
    logic signed [29:0]              acc1;
    logic signed [`SRR_SAMP_W-1:0]   mn0;
    logic signed [`SRR_SAMP_W-1:0]   mn1;
    logic signed [`SRR_SAMP_W-1:0]   mx0;
    logic signed [`SRR_SAMP_W-1:0]   mx1;
    logic [`SRR_WORD_W-1:0]          hold_max;
    logic [`SRR_CNT_W-1:0]           words;
    logic                            full;
    logic                            acq_we;
    logic [`SRR_ADDR_W-1:0]          acq_wa;
    logic [`SRR_WORD_W-1:0]          acq_wd;
    logic                            rd_valid;
    logic [`SRR_ADDR_W-1:0]          awg_ra;
    logic [`SRR_N_W-1:0]             rep;
    logic [`SRR_WORD_W-1:0]          dac;
    logic                            dac_valid;
  } srr_state_t;
endpackage

// [shared/srr_mem_if.sv]
// one write port and one registered read port of a sample buffer
`timescale 1ns/1ps
`include "srr_regs.svh"
interface srr_mem_if;
  logic                   we;
  logic [`SRR_ADDR_W-1:0] waddr;
  logic [`SRR_WORD_W-1:0] wdata;
  logic [`SRR_ADDR_W-1:0] raddr;
  logic [`SRR_WORD_W-1:0] rdata;
  modport user (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [hdl/srr_buf.sv]
// two-channel sample buffer with registered read data
`timescale 1ns/1ps
`include "srr_regs.svh"
module srr_buf (
  input  wire logic I_CLK,
  srr_mem_if.mem    bus
);
  logic [`SRR_WORD_W-1:0] mem [0:`SRR_MEM_DEPTH-1];
  logic [`SRR_WORD_W-1:0] rdata;

  always_ff @(posedge I_CLK) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
    rdata <= mem[bus.raddr];
  end

  assign bus.rdata = rdata;
endmodule

// [hdl/srr_top.sv]
// two-channel acquisition rate reducer and waveform sample repeater
`timescale 1ns/1ps
`include "srr_regs.svh"
module srr_top (
  input  wire logic                     I_CLK,
  input  wire logic                     I_RESET,
  input  wire logic                     I_SAMPLE_TICK,
  input  wire logic [1:0]               I_MODE,
  input  wire logic [`SRR_N_W-1:0]      I_DIV_N,
  input  wire logic                     I_ALT_ALLOC,
  input  wire logic [`SRR_SAMP_W-1:0]   I_ADC_CH0,
  input  wire logic [`SRR_SAMP_W-1:0]   I_ADC_CH1,
  input  wire logic                     I_ACQ_RUN,
  input  wire logic                     I_ACQ_RD_EN,
  input  wire logic [`SRR_ADDR_W-1:0]   I_ACQ_RD_ADDR,
  input  wire logic                     I_AWG_WR_EN,
  input  wire logic [`SRR_ADDR_W-1:0]   I_AWG_WR_ADDR,
  input  wire logic [`SRR_WORD_W-1:0]   I_AWG_WR_DATA,
  input  wire logic [`SRR_CNT_W-1:0]    I_AWG_LEN,
  input  wire logic                     I_AWG_RUN,
  output logic      [`SRR_WORD_W-1:0]   O_ACQ_RD_DATA,
  output logic                          O_ACQ_RD_VALID,
  output logic      [`SRR_CNT_W-1:0]    O_ACQ_WORDS,
  output logic                          O_ACQ_FULL,
  output logic      [`SRR_SAMP_W-1:0]   O_DAC_CH0,
  output logic      [`SRR_SAMP_W-1:0]   O_DAC_CH1,
  output logic                          O_DAC_STROBE
);
  // divisor of zero is taken as one
  function automatic logic [`SRR_N_W-1:0] eff_n(input logic [`SRR_N_W-1:0] n);
    return (n == '0) ? `SRR_N_W'h1 : n;
  endfunction

  function automatic logic signed [`SRR_SAMP_W-1:0] mean(
    input logic signed [29:0]        sum,
    input logic [`SRR_N_W-1:0]       n);
    logic signed [29:0] q;
    q = sum / $signed({14'h0, n});
    return q[`SRR_SAMP_W-1:0];
  endfunction

  function automatic logic signed [`SRR_SAMP_W-1:0] smin(
    input logic signed [`SRR_SAMP_W-1:0] a,
    input logic signed [`SRR_SAMP_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic signed [`SRR_SAMP_W-1:0] smax(
    input logic signed [`SRR_SAMP_W-1:0] a,
    input logic signed [`SRR_SAMP_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  srr_pkg::srr_state_t         s;
  srr_pkg::srr_state_t         next_s;
  logic [`SRR_N_W-1:0]         n;
  logic [`SRR_N_W:0]           grp_len;
  logic [`SRR_CNT_W-1:0]       acq_lim;
  logic [`SRR_CNT_W-1:0]       awg_lim;
  logic [`SRR_CNT_W-1:0]       awg_len;
  logic                        is_mm;
  logic                        is_avg;
  logic                        acq_last;
  logic                        in_max;
  logic signed [`SRR_SAMP_W-1:0] x0;
  logic signed [`SRR_SAMP_W-1:0] x1;
  logic [`SRR_CNT_W-1:0]       ra_next;

  srr_mem_if acq_bus ();
  srr_mem_if awg_bus ();

  srr_buf u_acq_buf (.I_CLK(I_CLK), .bus(acq_bus.mem));
  srr_buf u_awg_buf (.I_CLK(I_CLK), .bus(awg_bus.mem));

  assign acq_bus.we    = s.acq_we;
  assign acq_bus.waddr = s.acq_wa;
  assign acq_bus.wdata = s.acq_wd;
  assign acq_bus.raddr = I_ACQ_RD_ADDR;
  assign awg_bus.we    = I_AWG_WR_EN;
  assign awg_bus.waddr = I_AWG_WR_ADDR;
  assign awg_bus.wdata = I_AWG_WR_DATA;
  assign awg_bus.raddr = s.awg_ra;

  assign n        = eff_n(I_DIV_N);
  assign is_mm    = (I_MODE == `SRR_MODE_MM);
  assign is_avg   = (I_MODE == `SRR_MODE_AVG);
  assign grp_len  = is_mm ? {n, 1'b0} : {1'b0, n};
  assign acq_lim  = I_ALT_ALLOC ? `SRR_ACQ_DEPTH_ALT : `SRR_ACQ_DEPTH_DEF;
  assign awg_lim  = I_ALT_ALLOC ? `SRR_AWG_DEPTH_ALT : `SRR_AWG_DEPTH_DEF;
  assign awg_len  = (I_AWG_LEN == '0) ? `SRR_CNT_W'h1 :
                    (I_AWG_LEN > awg_lim) ? awg_lim : I_AWG_LEN;
  assign in_max   = (s.ast == srr_pkg::A_MAX);
  assign acq_last = I_SAMPLE_TICK && (s.grp == grp_len - 1'b1)
                    && (s.ast == srr_pkg::A_RUN || in_max);
  assign x0       = I_ADC_CH0;
  assign x1       = I_ADC_CH1;
  assign ra_next  = {1'b0, s.awg_ra} + 1'b1;

  always_comb begin
    logic first;
    logic do_wr;
    logic [`SRR_WORD_W-1:0] wd;
    logic signed [29:0] a0;
    logic signed [29:0] a1;
    first    = (s.grp == '0);
    do_wr    = 1'b0;
    wd       = '0;
    a0       = '0;
    a1       = '0;
    next_s   = s;
    next_s.acq_we    = 1'b0;
    next_s.dac_valid = 1'b0;
    next_s.rd_valid  = I_ACQ_RD_EN;

    case (s.ast)
      srr_pkg::A_IDLE: begin
        if (I_ACQ_RUN) begin
          next_s.ast   = srr_pkg::A_RUN;
          next_s.grp   = '0;
          next_s.words = '0;
          next_s.full  = 1'b0;
        end
      end
      srr_pkg::A_RUN, srr_pkg::A_MAX: begin
        if (in_max) begin
          // second word of the pair: maxima
          do_wr      = 1'b1;
          wd         = s.hold_max;
          next_s.ast = srr_pkg::A_RUN;
        end
        if (I_SAMPLE_TICK) begin
          // first sample of a group reloads every accumulator
          a0        = first ? 30'(x0) : s.acc0 + 30'(x0);
          a1        = first ? 30'(x1) : s.acc1 + 30'(x1);
          next_s.acc0 = a0;
          next_s.acc1 = a1;
          next_s.mn0  = first ? x0 : smin(s.mn0, x0);
          next_s.mn1  = first ? x1 : smin(s.mn1, x1);
          next_s.mx0  = first ? x0 : smax(s.mx0, x0);
          next_s.mx1  = first ? x1 : smax(s.mx1, x1);
          if (acq_last) begin
            next_s.grp = '0;
            do_wr      = 1'b1;
            if (is_avg) begin
              wd = {mean(a1, n), mean(a0, n)};
            end else if (is_mm) begin
              wd = {next_s.mn1, next_s.mn0};
              next_s.hold_max = {next_s.mx1, next_s.mx0};
              next_s.ast      = srr_pkg::A_MAX;
            end else begin
              wd = {x1, x0};
            end
          end else begin
            next_s.grp = s.grp + 1'b1;
          end
        end
        if (do_wr) begin
          if (s.words == acq_lim) begin
            next_s.full = 1'b1;
            next_s.ast  = srr_pkg::A_FULL;
          end else begin
            next_s.acq_we = 1'b1;
            next_s.acq_wa = s.words[`SRR_ADDR_W-1:0];
            next_s.acq_wd = wd;
            next_s.words  = s.words + 1'b1;
          end
        end
        if (!I_ACQ_RUN) begin
          next_s.ast = srr_pkg::A_IDLE;
        end
      end
      srr_pkg::A_FULL: begin
        if (!I_ACQ_RUN) begin
          next_s.ast = srr_pkg::A_IDLE;
        end
      end
      default: begin
        next_s.ast = srr_pkg::A_IDLE;
      end
    endcase

    case (s.wst)
      srr_pkg::W_IDLE: begin
        if (I_AWG_RUN) begin
          next_s.wst    = srr_pkg::W_PRIME;
          next_s.awg_ra = '0;
          next_s.rep    = '0;
        end
      end
      srr_pkg::W_PRIME: begin
        // lets the first word reach the read register
        next_s.wst = I_AWG_RUN ? srr_pkg::W_PLAY : srr_pkg::W_IDLE;
      end
      srr_pkg::W_PLAY: begin
        if (!I_AWG_RUN) begin
          next_s.wst = srr_pkg::W_IDLE;
        end else if (I_SAMPLE_TICK) begin
          next_s.dac       = awg_bus.rdata;
          next_s.dac_valid = 1'b1;
          if (s.rep == n - 1'b1) begin
            next_s.rep    = '0;
            next_s.awg_ra = (ra_next >= awg_len) ? '0 : ra_next[`SRR_ADDR_W-1:0];
          end else begin
            next_s.rep = s.rep + 1'b1;
          end
        end
      end
      default: begin
        next_s.wst = srr_pkg::W_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      s     <= '0;
      s.ast <= srr_pkg::A_IDLE;
      s.wst <= srr_pkg::W_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign O_ACQ_RD_DATA  = acq_bus.rdata;
  assign O_ACQ_RD_VALID = s.rd_valid;
  assign O_ACQ_WORDS    = s.words;
  assign O_ACQ_FULL     = s.full;
  assign O_DAC_CH0      = s.dac[`SRR_SAMP_W-1:0];
  assign O_DAC_CH1      = s.dac[`SRR_WORD_W-1:`SRR_SAMP_W];
  assign O_DAC_STROBE   = s.dac_valid;

  property p_strobe_from_tick;
    @(posedge I_CLK) disable iff (I_RESET)
    O_DAC_STROBE |-> $past(I_SAMPLE_TICK);
  endproperty
  a_strobe_from_tick: assert property (p_strobe_from_tick)
    else $error("output strobe without a sample tick");

  property p_repeat_holds;
    @(posedge I_CLK) disable iff (I_RESET)
    (s.wst == srr_pkg::W_PLAY && I_AWG_RUN && I_SAMPLE_TICK && s.rep != n - 1'b1)
      |=> O_DAC_STROBE && $stable(s.awg_ra);
  endproperty
  a_repeat_holds: assert property (p_repeat_holds)
    else $error("sample fetched before N repeats");

  property p_n_one_advances;
    @(posedge I_CLK) disable iff (I_RESET)
    (s.wst == srr_pkg::W_PLAY && I_AWG_RUN && I_SAMPLE_TICK && I_DIV_N <= 16'h1
      && awg_len > 15'h1) |=> !$stable(s.awg_ra);
  endproperty
  a_n_one_advances: assert property (p_n_one_advances)
    else $error("N of one did not advance playback");

  property p_play_in_range;
    @(posedge I_CLK) disable iff (I_RESET)
    (s.wst == srr_pkg::W_PLAY) |-> {1'b0, s.awg_ra} < awg_lim;
  endproperty
  a_play_in_range: assert property (p_play_in_range)
    else $error("playback address beyond buffer size");

  property p_words_in_range;
    @(posedge I_CLK) disable iff (I_RESET)
    O_ACQ_WORDS <= acq_lim;
  endproperty
  a_words_in_range: assert property (p_words_in_range)
    else $error("capture count beyond buffer size");

  property p_write_timed;
    @(posedge I_CLK) disable iff (I_RESET)
    s.acq_we |-> $past(acq_last) || $past(in_max);
  endproperty
  a_write_timed: assert property (p_write_timed)
    else $error("capture write not at a group end");

  property p_avg_n_one;
    @(posedge I_CLK) disable iff (I_RESET)
    (is_avg && I_DIV_N == 16'h1 && acq_last && s.words < acq_lim && !in_max)
      |=> s.acq_we && s.acq_wd[13:0] == $past(I_ADC_CH0);
  endproperty
  a_avg_n_one: assert property (p_avg_n_one)
    else $error("mean of one sample differs from the sample");

  property p_mm_half_rate;
    @(posedge I_CLK) disable iff (I_RESET)
    (is_mm && I_SAMPLE_TICK && s.ast == srr_pkg::A_RUN && s.grp == {1'b0, n - 1'b1})
      |=> !s.acq_we;
  endproperty
  a_mm_half_rate: assert property (p_mm_half_rate)
    else $error("min/max pair stored after only N samples");

  property p_pair_order;
    @(posedge I_CLK) disable iff (I_RESET)
    (in_max && s.acq_we && s.words < acq_lim)
      |-> $signed(s.acq_wd[13:0]) <= $signed(s.hold_max[13:0])
      ##1 s.acq_we && s.acq_wd == $past(s.hold_max);
  endproperty
  a_pair_order: assert property (p_pair_order)
    else $error("min/max pair out of order");
endmodule

// [verif/srr_conv_model.sv]
// converter model: sample ticks with random adc data for both channels
`timescale 1ns/1ps
`include "srr_regs.svh"
module srr_conv_model (
  input  wire logic                  i_clk,
  input  wire logic                  i_en,
  output logic                       o_tick,
  output logic [`SRR_SAMP_W-1:0]     o_ch0,
  output logic [`SRR_SAMP_W-1:0]     o_ch1
);
  initial begin
    o_tick = 1'b0;
    o_ch0  = '0;
    o_ch1  = '0;
  end

  // one conversion every second cycle; between ticks the data is inverted so stale values show
  always @(negedge i_clk) begin
    if (i_en && !o_tick) begin
      o_tick <= 1'b1;
      o_ch0  <= ($urandom % 8 == 0) ? 14'h2000 : `SRR_SAMP_W'($urandom);
      o_ch1  <= ($urandom % 8 == 0) ? 14'h1fff : `SRR_SAMP_W'($urandom);
    end else begin
      o_tick <= 1'b0;
      o_ch0  <= ~o_ch0;
      o_ch1  <= ~o_ch1;
    end
  end
endmodule

// [verif/tb.sv]
// self-checking bench of the sample rate reducer
`timescale 1ns/1ps
`include "srr_regs.svh"
module tb;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   en = 1'b0;
  logic                   cap_on = 1'b0;
  logic                   tick;
  logic [`SRR_SAMP_W-1:0] ch0, ch1, dac0, dac1;
  logic [1:0]             mode = 2'h0;
  logic [`SRR_N_W-1:0]    n_div = 16'h1;
  logic                   alt = 1'b0, acq_run = 1'b0, rd_en = 1'b0, wr_en = 1'b0, awg_run = 1'b0;
  logic [`SRR_ADDR_W-1:0] rd_addr = '0, wr_addr = '0;
  logic [`SRR_WORD_W-1:0] wr_data = '0, rd_data;
  logic [`SRR_CNT_W-1:0]  awg_len = '0, words;
  logic                   rd_valid, full, strobe;
  int                     err_total = 0, compares = 0, cyc = 0, tk = 0;
  logic [`SRR_WORD_W-1:0] q[$], dq[$], ex[$];

  srr_conv_model i_conv (.i_clk(clk), .i_en(en), .o_tick(tick), .o_ch0(ch0), .o_ch1(ch1));

  srr_top i_dut (
    .I_CLK(clk), .I_RESET(rst), .I_SAMPLE_TICK(tick), .I_MODE(mode), .I_DIV_N(n_div),
    .I_ALT_ALLOC(alt), .I_ADC_CH0(ch0), .I_ADC_CH1(ch1), .I_ACQ_RUN(acq_run),
    .I_ACQ_RD_EN(rd_en), .I_ACQ_RD_ADDR(rd_addr), .I_AWG_WR_EN(wr_en),
    .I_AWG_WR_ADDR(wr_addr), .I_AWG_WR_DATA(wr_data), .I_AWG_LEN(awg_len),
    .I_AWG_RUN(awg_run), .O_ACQ_RD_DATA(rd_data), .O_ACQ_RD_VALID(rd_valid),
    .O_ACQ_WORDS(words), .O_ACQ_FULL(full), .O_DAC_CH0(dac0), .O_DAC_CH1(dac1),
    .O_DAC_STROBE(strobe)
  );

  always #25 clk = ~clk;

  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // records converter samples, playback ticks and dac words; cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cap_on && tick) q.push_back({ch1, ch0});
    if (awg_run && tick) tk++;
    if (strobe === 1'b1) dq.push_back({dac1, dac0});
    if (cyc == 80000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one channel of one group reduced as the mode asks: mean, last, min or max
  function automatic logic [`SRR_SAMP_W-1:0] reduce(input logic [1:0] m, input int g,
                                                   input int b, input int c, input bit hi_sel);
    int s = 0, v = 0, lo = 8191, hi = -8192;
    for (int i = 0; i < g; i++) begin
      v = $signed(q[b+i][c*`SRR_SAMP_W +: `SRR_SAMP_W]);
      s += v;
      if (v < lo) lo = v;
      if (v > hi) hi = v;
    end
    if (m == 2'h0) return `SRR_SAMP_W'(s / g);
    if (m == 2'h2) return hi_sel ? `SRR_SAMP_W'(hi) : `SRR_SAMP_W'(lo);
    return `SRR_SAMP_W'(v);
  endfunction

  task automatic rd(input int a);
    int w;
    @(negedge clk);
    rd_addr = a[`SRR_ADDR_W-1:0];
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    w = 0;
    while (rd_valid !== 1'b1 && w < 3) begin
      @(negedge clk);
      w++;
    end
    chk(rd_valid, 1'b1);
  endtask

  // capture groups plus, when a group is longer than one sample, one stray sample that must be dropped, then read back
  task automatic run_cap(input logic [1:0] m, input int n, input int groups);
    int ne, g, w;
    ne = (n == 0) ? 1 : n;
    g = (m == 2'h2) ? 2 * ne : ne;
    repeat (2) @(negedge clk);
    mode = m;
    n_div = n[`SRR_N_W-1:0];
    acq_run = 1'b1;
    repeat (2) @(negedge clk);
    q.delete();
    cap_on = 1'b1;
    en = 1'b1;
    w = 0;
    while (q.size() < groups * g + (g > 1) && w < 20000) begin
      @(negedge clk);
      w++;
    end
    en = 1'b0;
    repeat (4) @(negedge clk);
    cap_on = 1'b0;
    ex.delete();
    for (int b = 0; b + g <= q.size(); b += g) begin
      ex.push_back({reduce(m, g, b, 1, 0), reduce(m, g, b, 0, 0)});
      if (m == 2'h2) ex.push_back({reduce(m, g, b, 1, 1), reduce(m, g, b, 0, 1)});
    end
    chk(words, ex.size());
    for (int i = 0; i < ex.size(); i++) begin
      rd(i);
      chk(rd_data, ex[i]);
    end
    acq_run = 1'b0;
  endtask

  // load a short waveform, play it past two wraps and check every presented word
  task automatic run_awg(input int n, input int len);
    int w;
    logic [`SRR_WORD_W-1:0] mem[$];
    for (int i = 0; i < len; i++) begin
      mem.push_back(`SRR_WORD_W'($urandom));
      @(negedge clk);
      wr_en = 1'b1;
      wr_addr = i[`SRR_ADDR_W-1:0];
      wr_data = mem[i];
      @(negedge clk);
      wr_en = 1'b0;
    end
    n_div = n[`SRR_N_W-1:0];
    awg_len = len[`SRR_CNT_W-1:0];
    awg_run = 1'b1;
    repeat (2) @(negedge clk);
    dq.delete();
    tk = 0;
    en = 1'b1;
    w = 0;
    while (tk < 2 * len * n + 1 && w < 2000) begin
      @(negedge clk);
      w++;
    end
    en = 1'b0;
    repeat (3) @(negedge clk);
    awg_run = 1'b0;
    chk(dq.size(), tk);
    for (int i = 0; i < dq.size(); i++) chk(dq[i], mem[(i / n) % len]);
    @(negedge clk);
  endtask

  initial begin
    int w;
    void'($urandom(52));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int m = 0; m < 4; m++) begin
      run_cap(m[1:0], 1, 3);
      run_cap(m[1:0], 2 + $urandom % 3, 4);
    end
    run_cap(2'h0, 0, 3);
    run_awg(1, 3);
    run_awg(3, 4);
    for (int a = 0; a < 2; a++) begin
      repeat (2) @(negedge clk);
      alt = a[0];
      mode = 2'h1;
      n_div = 16'h1;
      acq_run = 1'b1;
      repeat (2) @(negedge clk);
      en = 1'b1;
      w = 0;
      while (full !== 1'b1 && w < 40000) begin
        @(negedge clk);
        w++;
      end
      en = 1'b0;
      repeat (3) @(negedge clk);
      chk(words, a ? `SRR_ACQ_DEPTH_ALT : `SRR_ACQ_DEPTH_DEF);
      chk(full, 1'b1);
      acq_run = 1'b0;
    end
    report_and_stop();
  end
endmodule
